// ### src/pocs_cfg.svh
/*
  Constants of the power-on configuration sequencer: timing figures and counts.
  Assumes a 25 MHz mclk; included by the package and by pocs_seq.
*/
`ifndef POCS_CFG_SVH
`define POCS_CFG_SVH

// ----------------------------------------
// Clock and timing figures
// ----------------------------------------
`define POCS_CLK_MHZ 25
`define POCS_CFG_TIME_US 450
`define POCS_CFG_CYCLES (`POCS_CFG_TIME_US * `POCS_CLK_MHZ)
`define POCS_BANK_DELAY_US 2
`define POCS_BANK_CYCLES (`POCS_BANK_DELAY_US * `POCS_CLK_MHZ)
`define POCS_NUM_BANKS 4
`define POCS_NUM_PINS 8
`define POCS_CNT_W 16

`endif

// ### src/pocs_pkg.sv
/*
  Types of the power-on configuration sequencer.
  Assumes pocs_cfg.svh is on the include path.
*/
`include "pocs_cfg.svh"

package pocs_pkg;

  // ----------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------
  typedef enum logic [4:0] {
    POCS_OFF = 5'h01,
    POCS_LOAD = 5'h02,
    POCS_CLEAR = 5'h04,
    POCS_WAIT_OE = 5'h08,
    POCS_USER = 5'h10
  } pocs_state_t;

endpackage : pocs_pkg

// ### src/pocs_sync_if.sv
/*
  Interface carrying the synchronised supply indications between the
  synchroniser and the sequencer. Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface pocs_sync_if #(parameter int NB = 4);
  logic core_start;
  logic core_brownout;
  logic [NB-1:0] bank_good;
  modport src (output core_start, output core_brownout, output bank_good);
  modport dst (input core_start, input core_brownout, input bank_good);
endinterface : pocs_sync_if

`default_nettype wire

// ### src/pocs_sync.sv
/*
  Two-flop synchroniser for the supply monitor indications.
  Assumes monitor levels may change at any time relative to mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module pocs_sync
  import pocs_pkg::*;
#(
  parameter int NB = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic core_start_raw,
  input wire logic core_brownout_raw,
  input wire logic [NB-1:0] bank_good_raw,
  pocs_sync_if.src sync
);

  typedef struct packed {
    logic [NB+1:0] meta;
    logic [NB+1:0] stable;
  } pocs_sync_st_t;

  pocs_sync_st_t st_reg;
  pocs_sync_st_t st_next;

  // ----------------------------------------
  // Two stages; only stage two is read
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      st_next.meta = {core_start_raw, core_brownout_raw, bank_good_raw};
      st_next.stable = st_reg.meta;
    end
  end

  // Register with sync reset to brown-out asserted, supplies not good
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '{meta: {2'h1, {NB{1'b0}}}, stable: {2'h1, {NB{1'b0}}}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync.core_start = st_reg.stable[NB+1];
  assign sync.core_brownout = st_reg.stable[NB];
  assign sync.bank_good = st_reg.stable[NB-1:0];

endmodule : pocs_sync

`default_nettype wire

// ### src/pocs_seq.sv
/*
  Power-on configuration sequencer top: waits for the core supply, times
  the configuration copy, gates user mode on bank supplies, orders clear
  and output-enable release unless clear_pin_option holds clears into user mode, and restarts on core brown-out.
  Assumes qualified supply monitor levels and a free-running 25 MHz mclk;
  rst_n is held low by the core monitor while the core supply is not good.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pocs_cfg.svh"

module pocs_seq
  import pocs_pkg::*;
#(
  parameter int NB = `POCS_NUM_BANKS,
  parameter int NP = `POCS_NUM_PINS,
  parameter int CNT_W = `POCS_CNT_W,
  parameter int CFG_CYCLES = `POCS_CFG_CYCLES,
  parameter int BANK_CYCLES = `POCS_BANK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic core_start_raw,
  input wire logic core_brownout_raw,
  input wire logic [NB-1:0] bank_good_raw,
  input wire logic [NP-1:0] pad_over_bank,
  input wire logic clear_pin_option,
  input wire logic output_enable_pin_option,
  input wire logic ext_clear_n,
  input wire logic ext_output_enable,
  output logic supply_low_output_cutoff,
  output logic config_load,
  output logic user_mode,
  output logic reg_clear,
  output logic [NP-1:0] pin_oe,
  output logic [NP-1:0] pin_pullup_en
);

  // Refuse sizes that the counters or the pin vectors cannot serve
  if (NB < 1 || NP < 1 || CFG_CYCLES < 1 || BANK_CYCLES < 1 ||
      CFG_CYCLES >= (1 << CNT_W) || BANK_CYCLES >= (1 << CNT_W)) begin : g_param_check
    $error("pocs_seq: parameter out of range");
  end

  localparam logic [CNT_W-1:0] CFG_LAST = CNT_W'(CFG_CYCLES - 1);
  localparam logic [CNT_W-1:0] BANK_LAST = CNT_W'(BANK_CYCLES - 1);

  // ----------------------------------------
  // Synchronised monitor levels
  // ----------------------------------------
  pocs_sync_if #(.NB(NB)) sync ();

  pocs_sync #(.NB(NB)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .core_start_raw(core_start_raw),
    .core_brownout_raw(core_brownout_raw),
    .bank_good_raw(bank_good_raw),
    .sync(sync)
  );

  typedef struct packed {
    pocs_state_t state;
    logic [CNT_W-1:0] cfg_cnt;
    logic [CNT_W-1:0] bank_cnt;
    logic cfg_done;
    logic bank_ok;
    logic cutoff;
  } pocs_st_t;

  pocs_st_t st_reg;
  pocs_st_t st_next;

  logic all_banks;

  // Counter step, saturating at its last value
  function automatic logic [CNT_W-1:0] pocs_step(input logic [CNT_W-1:0] c,
                                                 input logic [CNT_W-1:0] last);
    pocs_step = (c == last) ? c : c + CNT_W'(1);
  endfunction : pocs_step

  assign all_banks = &sync.bank_good;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      st_next.cutoff = sync.core_brownout || !all_banks;
      // Bank delay restarts whenever any bank drops
      if (!all_banks) begin
        st_next.bank_cnt = '0;
        st_next.bank_ok = 1'b0;
      end else begin
        st_next.bank_cnt = pocs_step(st_reg.bank_cnt, BANK_LAST);
        st_next.bank_ok = st_reg.bank_ok || (st_reg.bank_cnt == BANK_LAST);
      end
      case (st_reg.state)
        POCS_OFF: begin
          st_next.cfg_cnt = '0;
          st_next.cfg_done = 1'b0;
          if (sync.core_start && !sync.core_brownout) begin
            st_next.state = POCS_LOAD;
          end
        end
        POCS_LOAD: begin
          if (sync.core_brownout) begin
            st_next.state = POCS_OFF;
          end else begin
            st_next.cfg_cnt = pocs_step(st_reg.cfg_cnt, CFG_LAST);
            if (st_reg.cfg_cnt == CFG_LAST) begin
              st_next.cfg_done = 1'b1;
            end
            // Both the full time and the bank delay must be met
            if (st_reg.cfg_done && (st_reg.bank_ok || all_banks && st_reg.bank_cnt ==
                BANK_LAST)) begin
              st_next.state = POCS_CLEAR;
            end
          end
        end
        POCS_CLEAR: begin
          if (sync.core_brownout) begin
            st_next.state = POCS_OFF;
          end else if (!clear_pin_option || ext_clear_n) begin
            st_next.state = POCS_WAIT_OE;
          end else if (all_banks && (!output_enable_pin_option || ext_output_enable)) begin
            st_next.state = POCS_USER;
          end
        end
        POCS_WAIT_OE: begin
          if (sync.core_brownout) begin
            st_next.state = POCS_OFF;
          end else if (all_banks && (!output_enable_pin_option || ext_output_enable)) begin
            st_next.state = POCS_USER;
          end
        end
        POCS_USER: begin
          // Only the core supply can end user mode
          if (sync.core_brownout) begin
            st_next.state = POCS_OFF;
          end
        end
        default: begin
          st_next.state = POCS_OFF;
        end
      endcase
    end
  end

  // State register; reset is driven by the core supply monitor
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '{state: POCS_OFF, cfg_cnt: '0, bank_cnt: '0,
                  cfg_done: 1'b0, bank_ok: 1'b0, cutoff: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic in_user;
  logic clears_held;
  logic oe_allowed;

  assign in_user = (st_reg.state == POCS_USER);
  // With the clear option, clears persist in user mode until released
  assign clears_held = !(st_reg.state == POCS_WAIT_OE || in_user) ||
                       (clear_pin_option && !ext_clear_n);
  // Brown-out tri-states combinationally, without waiting a cycle
  assign oe_allowed = in_user && !sync.core_brownout && !st_reg.cutoff &&
                      (!output_enable_pin_option || ext_output_enable);

  assign supply_low_output_cutoff = st_reg.cutoff;
  assign config_load = (st_reg.state == POCS_LOAD);
  assign user_mode = in_user;
  assign reg_clear = clears_held;
  assign pin_oe = {NP{oe_allowed}} & ~pad_over_bank;
  assign pin_pullup_en = {NP{!in_user}};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_brownout_in_user;
    in_user && sync.core_brownout && clk_en;
  endsequence

  property p_cutoff_off;
    @(posedge mclk) disable iff (!rst_n) supply_low_output_cutoff |-> pin_oe == '0;
  endproperty
  a_cutoff_off: assert property (p_cutoff_off) else $error("Drive during cutoff");

  property p_no_oe_unconfigured;
    @(posedge mclk) disable iff (!rst_n) !user_mode |-> pin_oe == '0;
  endproperty
  a_no_oe_unconfigured: assert property (p_no_oe_unconfigured)
    else $error("Drive before user mode");

  property p_pullup;
    @(posedge mclk) disable iff (!rst_n) config_load |-> pin_pullup_en == {NP{1'b1}};
  endproperty
  a_pullup: assert property (p_pullup) else $error("Pull-ups off in load");

  property p_banks_gate;
    @(posedge mclk) disable iff (!rst_n)
      $rose(user_mode) |-> $past(sync.bank_good) == {NB{1'b1}};
  endproperty
  a_banks_gate: assert property (p_banks_gate) else $error("User mode with bank low");

  property p_brownout;
    @(posedge mclk) disable iff (!rst_n)
      s_brownout_in_user |-> pin_oe == '0 ##1 (!user_mode && reg_clear);
  endproperty
  a_brownout: assert property (p_brownout) else $error("Brown-out not handled");

  property p_bank_no_reset;
    @(posedge mclk) disable iff (!rst_n)
      (in_user && !sync.core_brownout && clk_en) |=> user_mode;
  endproperty
  a_bank_no_reset: assert property (p_bank_no_reset) else $error("User mode left");

  property p_clear_before_oe;
    @(posedge mclk) disable iff (!rst_n) (pin_oe != '0 && !clear_pin_option) |-> !reg_clear;
  endproperty
  a_clear_before_oe: assert property (p_clear_before_oe)
    else $error("Outputs before clear release");

  property p_ext_clear;
    @(posedge mclk) disable iff (!rst_n) (clear_pin_option && !ext_clear_n) |-> reg_clear;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("Clear released early");

  property p_ext_oe;
    @(posedge mclk) disable iff (!rst_n)
      (output_enable_pin_option && !ext_output_enable) |-> pin_oe == '0;
  endproperty
  a_ext_oe: assert property (p_ext_oe) else $error("Drive without enable");

  property p_full_time;
    @(posedge mclk) disable iff (!rst_n)
      $rose(user_mode) |-> $past(st_reg.cfg_done);
  endproperty
  a_full_time: assert property (p_full_time) else $error("User mode before full time");

  property p_pad_over;
    @(posedge mclk) disable iff (!rst_n) (pad_over_bank != '0) |-> (pin_oe & pad_over_bank) == '0;
  endproperty
  a_pad_over: assert property (p_pad_over) else $error("Drive against pad");

endmodule : pocs_seq

`default_nettype wire

// ### testbench/pocs_supply_model.sv
/*
  Behavioural model of the core and bank supply monitors.
  Assumes the bench sets the supply levels off the clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module pocs_supply_model #(
  parameter int NB = 4
) (
  input wire logic core_on,
  input wire logic [NB-1:0] bank_on,
  output logic core_start_raw,
  output logic core_brownout_raw,
  output logic [NB-1:0] bank_good_raw
);
  // Core above start level, or sagged below brown-out level
  assign core_start_raw = core_on;
  assign core_brownout_raw = !core_on;
  // Each bank monitor reports its own supply
  assign bank_good_raw = bank_on;
endmodule : pocs_supply_model

`default_nettype wire

// ### testbench/power_on_config_sequencer_test.sv
/*
  Self-checking bench of the power-on configuration sequencer.
  Assumes pocs_seq, its package and the supply model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module power_on_config_sequencer_test;
  import pocs_pkg::*;
  localparam int CFG = 20;
  localparam int BANK = 4;
  logic mclk, rst_n, clk_en, core_on, clr_opt, oe_opt, ext_clear_n, ext_oe;
  logic core_start_raw, core_brownout_raw, cutoff, config_load, user_mode, reg_clear;
  logic [3:0] bank_on, bank_good_raw;
  logic [7:0] pad_over_bank, pin_oe, pin_pullup_en;
  int n_errors, checked, n;

  // ----------------------------------------
  // Design, supply model and clock
  // ----------------------------------------
  pocs_seq #(.CFG_CYCLES(CFG), .BANK_CYCLES(BANK)) uut (.mclk(mclk), .rst_n(rst_n),
    .clk_en(clk_en), .core_start_raw(core_start_raw), .core_brownout_raw(core_brownout_raw),
    .bank_good_raw(bank_good_raw), .pad_over_bank(pad_over_bank), .clear_pin_option(clr_opt),
    .output_enable_pin_option(oe_opt), .ext_clear_n(ext_clear_n), .ext_output_enable(ext_oe),
    .supply_low_output_cutoff(cutoff), .config_load(config_load), .user_mode(user_mode),
    .reg_clear(reg_clear), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en));
  pocs_supply_model #(.NB(4)) monitor (.core_on(core_on), .bank_on(bank_on),
    .core_start_raw(core_start_raw), .core_brownout_raw(core_brownout_raw),
    .bank_good_raw(bank_good_raw));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Advance n edges, then step just past the last one
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Count edges until user mode, bounded
  task automatic wait_user(input int lim, output int k);
    k = 0;
    while (user_mode !== 1'b1 && k < lim) begin
      step(1);
      k++;
    end
  endtask : wait_user

  // Sag the core below the brown-out level, then bring it back
  task automatic core_cycle(input logic [3:0] banks);
    core_on = 1'b0;
    step(6);
    bank_on = banks;
    core_on = 1'b1;
  endtask : core_cycle

  task automatic final_report;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("cutoff", cutoff, 8'h01);
    chk("oe", pin_oe, 8'h00);
    chk("pullup", pin_pullup_en, 8'hff);
    chk("clear", reg_clear, 8'h01);
    chk("user", user_mode, 8'h00);
  endtask : t_reset

  task automatic t_powerup;
    core_cycle(4'hf);
    step(4);
    chk("load", config_load, 8'h01);
    chk("oe_load", pin_oe, 8'h00);
    chk("pull_load", pin_pullup_en, 8'hff);
    wait_user(CFG + 20, n);
    chk("cfg_time", (n >= CFG - 4 && n <= CFG + 10), 8'h01);
    chk("clear_user", reg_clear, 8'h00);
    chk("oe_user", pin_oe, 8'hff);
    chk("pull_user", pin_pullup_en, 8'h00);
    chk("cutoff_ok", cutoff, 8'h00);
  endtask : t_powerup

  task automatic t_bank_drop;
    bank_on = 4'he;
    step(5);
    chk("bank_user", user_mode, 8'h01);
    chk("bank_cut", cutoff, 8'h01);
    chk("bank_oe", pin_oe, 8'h00);
    bank_on = 4'hf;
    step(5);
    // Hold the pad condition across an edge so the checker sees it too
    pad_over_bank = 8'h81;
    step(1);
    chk("pad_oe", pin_oe, 8'h7e);
    pad_over_bank = 8'h00;
  endtask : t_bank_drop

  task automatic t_brownout;
    core_on = 1'b0;
    step(4);
    chk("bo_oe", pin_oe, 8'h00);
    chk("bo_user", user_mode, 8'h00);
    chk("bo_pull", pin_pullup_en, 8'hff);
    core_on = 1'b1;
    wait_user(CFG + 20, n);
    chk("restart", (n >= CFG && n <= CFG + 10), 8'h01);
  endtask : t_brownout

  task automatic t_late_bank;
    core_cycle(4'h7);
    step(CFG + 15);
    chk("late_user", user_mode, 8'h00);
    chk("late_oe", pin_oe, 8'h00);
    bank_on = 4'hf;
    wait_user(BANK + 20, n);
    chk("late_delay", (n >= BANK && n <= BANK + 8), 8'h01);
  endtask : t_late_bank

  task automatic t_clear_opt;
    clr_opt = 1'b1;
    ext_clear_n = 1'b0;
    core_cycle(4'hf);
    wait_user(CFG + 20, n);
    chk("hold_user", user_mode, 8'h01);
    chk("hold_clear", reg_clear, 8'h01);
    chk("hold_oe", pin_oe, 8'hff);
    ext_clear_n = 1'b1;
    step(3);
    chk("rel_clear", reg_clear, 8'h00);
    clr_opt = 1'b0;
  endtask : t_clear_opt

  task automatic t_oe_opt;
    oe_opt = 1'b1;
    ext_oe = 1'b0;
    core_cycle(4'hf);
    step(CFG + 15);
    chk("oe_hold_user", user_mode, 8'h00);
    chk("oe_hold", pin_oe, 8'h00);
    ext_oe = 1'b1;
    wait_user(6, n);
    chk("oe_rel", pin_oe, 8'hff);
    oe_opt = 1'b0;
  endtask : t_oe_opt

  // Clock enable low freezes the synchroniser and the cutoff register
  task automatic t_freeze;
    clk_en = 1'b0;
    bank_on = 4'he;
    step(6);
    chk("frz_cut", cutoff, 8'h00);
    chk("frz_user", user_mode, 8'h01);
    clk_en = 1'b1;
    step(5);
    chk("thaw_cut", cutoff, 8'h01);
    bank_on = 4'hf;
  endtask : t_freeze

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    n_errors = 0;
    checked = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    core_on = 1'b0;
    bank_on = 4'h0;
    pad_over_bank = 8'h00;
    clr_opt = 1'b0;
    oe_opt = 1'b0;
    ext_clear_n = 1'b1;
    ext_oe = 1'b1;
    step(12);
    t_reset();
    rst_n = 1'b1;
    t_powerup();
    t_bank_drop();
    t_brownout();
    t_late_bank();
    t_clear_opt();
    t_oe_opt();
    t_freeze();
    final_report();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    final_report();
  end
endmodule : power_on_config_sequencer_test

`default_nettype wire
